// ---- rtl/vsad_pkg.sv ----
// Constants for the bus slave address decode block
// Function
// - Wide space on: A24 decode, all switches compared, modifiers 0x39 and 0x3D only.
// - Wide space off: A16 decode, modifiers 0x29 and 0x2D only.
// - In A16 space only switches A15 down to A9 are compared.
// - A switch that is on compares as one, off compares as zero.
// - Factory setting A15 and A14 on, A16 space, base 0xC000.
// - Interrupt acknowledge and bus grant chains pass through one register stage, one clock late.
// - Shared memory readable and writable by the internal processor at any time, no handshake.
// - Each channel has a relay routing it to the test connector.
// - Channel relays follow a dedicated relay control register.
// - Mode register connects calibration bus and check resistor to test connector.
// - Check resistor may be switched onto the test connector.
// - Base on any 256-word boundary, window of 256 sixteen-bit registers.
package vsad_pkg;
    localparam int ADDR_MSB = 23;
    localparam int BASE_LSB = 9;
    localparam int NARROW_MSB = 15;
    localparam int IDX_W = 8;
    localparam int DATA_W = 16;
    localparam int SW_W = ADDR_MSB - BASE_LSB + 1;
    localparam int SW_NARROW_W = NARROW_MSB - BASE_LSB + 1;
    localparam logic [5:0] AM_WIDE_DATA = 6'h39;
    localparam logic [5:0] AM_WIDE_PROG = 6'h3d;
    localparam logic [5:0] AM_NARROW_USER = 6'h29;
    localparam logic [5:0] AM_NARROW_SUPV = 6'h2d;
    localparam logic [SW_W-1:0] FACTORY_SWITCH = 15'h0060;
    localparam logic [15:0] FACTORY_BASE = 16'hc000;
    localparam logic [IDX_W-1:0] RELAY_IDX = 8'h20;
    localparam logic [IDX_W-1:0] MODE_IDX = 8'h21;
    localparam int MODE_CALBUS_BIT = 0;
    localparam int MODE_CHECKRES_BIT = 1;
    localparam logic [DATA_W-1:0] RESET_WORD = 16'h0000;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ACCESS = 3'b010,
        ST_ACK = 3'b100
    } vsad_state_t;
endpackage : vsad_pkg

// ---- rtl/vsad_dpram.sv ----
// Dual-port register memory shared by the bus and the internal processor
`timescale 1ns/100ps
`default_nettype none
module vsad_dpram #(
    parameter int WIDTH = 16,
    parameter int AW = 8
) (
    // Clock
    input wire logic clk,
    // Bus port
    input wire logic aEn,
    input wire logic aWe,
    input wire logic [AW-1:0] aAddr,
    input wire logic [WIDTH-1:0] aWdata,
    output logic [WIDTH-1:0] aRdata,
    // Processor port
    input wire logic bEn,
    input wire logic bWe,
    input wire logic [AW-1:0] bAddr,
    input wire logic [WIDTH-1:0] bWdata,
    output logic [WIDTH-1:0] bRdata
);
    logic [WIDTH-1:0] mem [2**AW];

    // Bus port wins a same-word write collision
    always_ff @(posedge clk) begin
        if (bEn && bWe && !(aEn && aWe && aAddr == bAddr)) begin
            mem[bAddr] <= bWdata;
        end
        if (aEn && aWe) begin
            mem[aAddr] <= aWdata;
        end
        if (aEn) begin
            aRdata <= mem[aAddr];
        end
        if (bEn) begin
            bRdata <= mem[bAddr];
        end
    end
endmodule : vsad_dpram
`default_nettype wire

// ---- rtl/vsad_slave.sv ----
// Bus slave: address decode, shared memory, test relays, daisy chains
`timescale 1ns/100ps
`default_nettype none
module vsad_slave
    import vsad_pkg::*;
#(
    parameter int NUM_CH = 16,
    parameter int BG_LEVELS = 4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Board switches
    input wire logic [SW_W-1:0] addrSwitch,
    input wire logic wideSpaceSelect,
    // Bus cycle inputs
    input wire logic [ADDR_MSB:1] vmeAddr,
    input wire logic [5:0] vmeAm,
    input wire logic asN,
    input wire logic ds0N,
    input wire logic ds1N,
    input wire logic writeN,
    input wire logic [DATA_W-1:0] dataIn,
    // Bus cycle outputs
    output logic [DATA_W-1:0] dataOut,
    output logic dataOeN,
    output logic dtackN,
    output logic dtackOeN,
    // Daisy chains
    input wire logic iackInN,
    output logic iackOutN,
    input wire logic [BG_LEVELS-1:0] bgInN,
    output logic [BG_LEVELS-1:0] bgOutN,
    // Internal processor port
    input wire logic cpuEn,
    input wire logic cpuWe,
    input wire logic [IDX_W-1:0] cpuAddr,
    input wire logic [DATA_W-1:0] cpuWdata,
    output logic [DATA_W-1:0] cpuRdata,
    // Test connector routing
    output logic [NUM_CH-1:0] relayOn,
    output logic calBusEn,
    output logic checkResEn
);
    vsad_state_t state_r, state_nxt;
    logic amOk, addrOk, hit, fullWord, anyDs, memEn, memWe;
    logic wrFull_r, wrFull_nxt, isRead_r, isRead_nxt;
    logic [IDX_W-1:0] idx_r, idx_nxt;
    logic [DATA_W-1:0] wdata_r, wdata_nxt, memRdata;
    logic [DATA_W-1:0] dataOut_r, dataOut_nxt;
    logic dataOeN_r, dataOeN_nxt, dtackN_r, dtackN_nxt;
    logic [NUM_CH-1:0] relay_r, relay_nxt;
    logic calBus_r, calBus_nxt, checkRes_r, checkRes_nxt;
    logic iack_r;
    logic [BG_LEVELS-1:0] bg_r;

    assign anyDs = !ds0N || !ds1N;
    assign fullWord = !ds0N && !ds1N;

    always_comb begin
        if (wideSpaceSelect) begin
            amOk = (vmeAm == AM_WIDE_DATA) || (vmeAm == AM_WIDE_PROG);
        end else begin
            amOk = (vmeAm == AM_NARROW_USER) || (vmeAm == AM_NARROW_SUPV);
        end
    end

    always_comb begin
        if (wideSpaceSelect) begin
            addrOk = vmeAddr[ADDR_MSB:BASE_LSB] == addrSwitch;
        end else begin
            addrOk = vmeAddr[NARROW_MSB:BASE_LSB] == addrSwitch[SW_NARROW_W-1:0];
        end
    end

    assign hit = !asN && anyDs && amOk && addrOk;

    assign memEn = (state_r == ST_IDLE) && hit;
    assign memWe = memEn && !writeN && fullWord;

    vsad_dpram #(
        .WIDTH(DATA_W),
        .AW(IDX_W)
    ) u_mem (
        .clk(core_clk),
        .aEn(memEn),
        .aWe(memWe),
        .aAddr(vmeAddr[BASE_LSB-1:1]),
        .aWdata(dataIn),
        .aRdata(memRdata),
        .bEn(cpuEn),
        .bWe(cpuWe),
        .bAddr(cpuAddr),
        .bWdata(cpuWdata),
        .bRdata(cpuRdata)
    );

    // Cycle sequencer
    always_comb begin
        state_nxt = state_r;
        idx_nxt = idx_r;
        wdata_nxt = wdata_r;
        wrFull_nxt = wrFull_r;
        isRead_nxt = isRead_r;
        dataOut_nxt = dataOut_r;
        dataOeN_nxt = dataOeN_r;
        dtackN_nxt = dtackN_r;
        case (state_r)
            ST_IDLE: begin
                dataOeN_nxt = 1'b1;
                dtackN_nxt = 1'b1;
                if (hit) begin
                    state_nxt = ST_ACCESS;
                    idx_nxt = vmeAddr[BASE_LSB-1:1];
                    wdata_nxt = dataIn;
                    wrFull_nxt = memWe;
                    isRead_nxt = writeN;
                end
            end
            ST_ACCESS: begin
                state_nxt = ST_ACK;
                dtackN_nxt = 1'b0;
                dataOut_nxt = memRdata;
                dataOeN_nxt = !isRead_r;
            end
            ST_ACK: begin
                if (asN || !anyDs) begin
                    state_nxt = ST_IDLE;
                    dtackN_nxt = 1'b1;
                    dataOeN_nxt = 1'b1;
                    wrFull_nxt = 1'b0;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                dtackN_nxt = 1'b1;
                dataOeN_nxt = 1'b1;
            end
        endcase
    end

    always_comb begin
        relay_nxt = relay_r;
        calBus_nxt = calBus_r;
        checkRes_nxt = checkRes_r;
        if (state_r == ST_ACCESS && wrFull_r) begin
            if (idx_r == RELAY_IDX) begin
                relay_nxt = wdata_r[NUM_CH-1:0];
            end
            if (idx_r == MODE_IDX) begin
                calBus_nxt = wdata_r[MODE_CALBUS_BIT];
                checkRes_nxt = wdata_r[MODE_CHECKRES_BIT];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_r <= ST_IDLE;
            idx_r <= '0;
            wdata_r <= RESET_WORD;
            wrFull_r <= 1'b0;
            isRead_r <= 1'b0;
            dataOut_r <= RESET_WORD;
            dataOeN_r <= 1'b1;
            dtackN_r <= 1'b1;
            relay_r <= '0;
            calBus_r <= 1'b0;
            checkRes_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            idx_r <= idx_nxt;
            wdata_r <= wdata_nxt;
            wrFull_r <= wrFull_nxt;
            isRead_r <= isRead_nxt;
            dataOut_r <= dataOut_nxt;
            dataOeN_r <= dataOeN_nxt;
            dtackN_r <= dtackN_nxt;
            relay_r <= relay_nxt;
            calBus_r <= calBus_nxt;
            checkRes_r <= checkRes_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            iack_r <= 1'b1;
            bg_r <= '1;
        end else begin
            iack_r <= iackInN;
            bg_r <= bgInN;
        end
    end

    assign dataOut = dataOut_r;
    assign dataOeN = dataOeN_r;
    assign dtackN = dtackN_r;
    assign dtackOeN = dtackN_r;
    assign iackOutN = iack_r;
    assign bgOutN = bg_r;
    assign relayOn = relay_r;
    assign calBusEn = calBus_r;
    assign checkResEn = checkRes_r;

    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    wideAm_a: assert property (
        state_r == ST_IDLE && wideSpaceSelect && vmeAm != AM_WIDE_DATA && vmeAm != AM_WIDE_PROG
        |=> state_r == ST_IDLE && dtackN) else $error("wide space accepted bad modifier");
    narrowAm_a: assert property (
        state_r == ST_IDLE && !wideSpaceSelect && vmeAm != AM_NARROW_USER && vmeAm != AM_NARROW_SUPV
        |=> state_r == ST_IDLE) else $error("narrow space accepted bad modifier");
    narrowUpper_a: assert property (
        state_r == ST_IDLE && !wideSpaceSelect && !asN && anyDs && vmeAm == AM_NARROW_USER
        && vmeAddr[NARROW_MSB:BASE_LSB] == addrSwitch[SW_NARROW_W-1:0]
        |=> state_r == ST_ACCESS ##1 !dtackN) else $error("narrow match not accepted");
    wideMiss_a: assert property (
        state_r == ST_IDLE && wideSpaceSelect && vmeAddr[ADDR_MSB:BASE_LSB] != addrSwitch
        |=> state_r == ST_IDLE) else $error("wide mismatch accepted");
    chainPass_a: assert property (
        ##1 iackOutN == $past(iackInN) && bgOutN == $past(bgInN)) else $error("daisy chain not passed");
    relayLoad_a: assert property (
        memWe && vmeAddr[BASE_LSB-1:1] == RELAY_IDX
        |=> ##1 relayOn == $past(dataIn, 2)) else $error("relay register not loaded");
    modeLoad_a: assert property (
        memWe && vmeAddr[BASE_LSB-1:1] == MODE_IDX
        |=> ##1 checkResEn == $past(dataIn[MODE_CHECKRES_BIT], 2)
        && calBusEn == $past(dataIn[MODE_CALBUS_BIT], 2)) else $error("mode register not loaded");
    byteWrite_a: assert property (
        memEn && !writeN && !fullWord |=> ##1 $stable(relayOn) && $stable(calBusEn) && $stable(checkResEn))
        else $error("byte write stored");
    noAnswer_a: assert property (
        state_r == ST_IDLE && !hit |=> state_r == ST_IDLE ##1 dtackN && dataOeN) else $error("answer without select");
    winAck_a: assert property (
        memEn |=> ##1 !dtackN && dataOeN == !$past(writeN, 2)) else $error("missing acknowledge");

    factoryBase_c: cover property (!wideSpaceSelect && addrSwitch == FACTORY_SWITCH
        && {vmeAddr[NARROW_MSB:BASE_LSB], 9'h000} == FACTORY_BASE && memEn);
    readCycle_c: cover property (memEn && writeN ##2 !dataOeN);
    wideWrite_c: cover property (memWe && wideSpaceSelect);
    relaySet_c: cover property (relayOn != '0 && checkResEn);
endmodule : vsad_slave
`default_nettype wire

// ---- tb/vsad_master.sv ----
// Bus master model running single-word cycles against the slave
`timescale 1ns/100ps
`default_nettype none
module vsad_master
    import vsad_pkg::*;
(
    // Clock and slave answer
    input wire logic core_clk,
    input wire logic dtackN,
    input wire logic dtackOeN,
    input wire logic dataOeN,
    input wire logic [DATA_W-1:0] dataOut,
    // Cycle lines
    output logic [ADDR_MSB:1] vmeAddr,
    output logic [5:0] vmeAm,
    output logic asN,
    output logic ds0N,
    output logic ds1N,
    output logic writeN,
    output logic [DATA_W-1:0] dataIn
);
    // Terminated lines float high when released
    task automatic releaseBus();
        vmeAddr = '1;
        vmeAm = 6'h3f;
        asN = 1'b1;
        ds0N = 1'b1;
        ds1N = 1'b1;
        writeN = 1'b1;
        dataIn = '1;
    endtask : releaseBus
    initial releaseBus();
    task automatic cycle(input logic [ADDR_MSB:1] a, input logic [5:0] am, input logic wr, input logic oneByte,
                         input logic [DATA_W-1:0] wd, output logic ack, output logic [DATA_W-1:0] rd,
                         output logic oe, output logic dOe);
        int i;
        @(negedge core_clk);
        vmeAddr = a;
        vmeAm = am;
        writeN = ~wr;
        dataIn = wr ? wd : '1;
        asN = 1'b0;
        ds0N = 1'b0;
        ds1N = oneByte;
        ack = 1'b0;
        rd = 'x;
        oe = 1'b1;
        dOe = 1'b1;
        // Answer looked at where settled, strobes held one more rising edge
        for (i = 0; i < 8 && !ack; i++) begin
            @(negedge core_clk);
            oe = dataOeN;
            dOe = dtackOeN;
            if (dtackN === 1'b0) begin
                ack = 1'b1;
                rd = dataOut;
            end
        end
        @(negedge core_clk);
        releaseBus();
        @(negedge core_clk);
    endtask : cycle
endmodule : vsad_master
`default_nettype wire

// ---- tb/vme_slave_address_decode_bench.sv ----
// Self-checking bench for the bus slave address decode block
`timescale 1ns/100ps
`default_nettype none
module vme_slave_address_decode_bench;
    import vsad_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [SW_W-1:0] addrSwitch = FACTORY_SWITCH;
    logic wideSpaceSelect = 1'b0;
    logic [ADDR_MSB:1] vmeAddr;
    logic [5:0] vmeAm;
    logic asN, ds0N, ds1N, writeN, dataOeN, dtackN, dtackOeN, iackOutN, calBusEn, checkResEn;
    logic [DATA_W-1:0] dataIn, dataOut, cpuRdata;
    logic iackInN = 1'b1;
    logic [3:0] bgInN = 4'hf;
    logic [3:0] bgOutN;
    logic cpuEn = 1'b0;
    logic cpuWe = 1'b0;
    logic [IDX_W-1:0] cpuAddr = 8'h00;
    logic [DATA_W-1:0] cpuWdata = 16'h0000;
    logic [15:0] relayOn;
    logic [15:0] mem [0:255];
    logic [4:0] chain;
    logic [5:0] amTab [0:3] = '{6'h29, 6'h2d, 6'h39, 6'h3d};
    int nMismatch = 0;
    int testsRun = 0;
    int k;
    integer seed = 32'h6bd5;
    logic [14:0] sw;
    logic [7:0] idx;
    logic [15:0] v;
    always #50 core_clk = ~core_clk;
    vsad_slave uut (.core_clk(core_clk), .srst(srst), .addrSwitch(addrSwitch), .wideSpaceSelect(wideSpaceSelect),
        .vmeAddr(vmeAddr), .vmeAm(vmeAm), .asN(asN), .ds0N(ds0N), .ds1N(ds1N), .writeN(writeN), .dataIn(dataIn),
        .dataOut(dataOut), .dataOeN(dataOeN), .dtackN(dtackN), .dtackOeN(dtackOeN), .iackInN(iackInN),
        .iackOutN(iackOutN),
        .bgInN(bgInN), .bgOutN(bgOutN), .cpuEn(cpuEn), .cpuWe(cpuWe), .cpuAddr(cpuAddr), .cpuWdata(cpuWdata),
        .cpuRdata(cpuRdata), .relayOn(relayOn), .calBusEn(calBusEn), .checkResEn(checkResEn));
    vsad_master m (.core_clk(core_clk), .dtackN(dtackN), .dtackOeN(dtackOeN), .dataOeN(dataOeN), .dataOut(dataOut),
        .vmeAddr(vmeAddr),
        .vmeAm(vmeAm), .asN(asN), .ds0N(ds0N), .ds1N(ds1N), .writeN(writeN), .dataIn(dataIn));
    task automatic chkWord(string nm, logic [15:0] e, logic [15:0] g);
        testsRun++;
        if (g !== e) begin
            nMismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chkWord
    task automatic chkBit(string nm, logic e, logic g);
        chkWord(nm, {15'h0, e}, {15'h0, g});
    endtask : chkBit
    task automatic printVerdict();
        $display("checks %0d mismatches %0d", testsRun, nMismatch);
        if (nMismatch == 0 && testsRun > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : printVerdict
    // Bus access with expected acknowledge, model memory update and read compare
    task automatic acc(logic [23:1] a, logic [5:0] am, logic wr, logic [15:0] wd, logic expAck, logic oneByte);
        logic ack, oe, dOe;
        logic [15:0] rd;
        m.cycle(a, am, wr, oneByte, wd, ack, rd, oe, dOe);
        chkBit("ack", expAck, ack);
        chkBit("dataOeN", !(expAck && !wr), oe);
        chkBit("dtackOeN", !expAck, dOe);
        if (expAck && wr && !oneByte) mem[a[8:1]] = wd;
        if (expAck && !wr) chkWord("rdata", mem[a[8:1]], rd);
    endtask : acc
    function automatic logic [23:1] mk(logic [14:0] s, logic wide, logic [7:0] i, logic [7:0] hi);
        return wide ? {s, i} : {hi, s[6:0], i};
    endfunction : mk
    task automatic resetChk();
        chkWord("relayOn", 16'h0000, relayOn);
        chkBit("calBusEn", 1'b0, calBusEn);
        chkBit("checkResEn", 1'b0, checkResEn);
        chkBit("dtackN", 1'b1, dtackN);
        chkBit("dtackOeN", 1'b1, dtackOeN);
    endtask : resetChk
    initial begin
        repeat (3) @(posedge core_clk);
        @(negedge core_clk) srst = 1'b0;
        resetChk();
        $display("test reset done");
        for (k = 0; k < 2; k++) begin
            acc({8'h5a, 15'h6000 + 15'(k)}, amTab[k], 1'b1, 16'h1234 + 16'(k), 1'b1, 1'b0);
            acc({8'ha5, 15'h6000 + 15'(k)}, amTab[k], 1'b0, 16'h0000, 1'b1, 1'b0);
            acc({8'h00, 15'h6000}, amTab[k + 2], 1'b0, 16'h0000, 1'b0, 1'b0);
        end
        acc({8'h00, 15'h2000}, 6'h29, 1'b0, 16'h0000, 1'b0, 1'b0);
        $display("test factory done");
        for (k = 0; k < 16; k++) begin
            wideSpaceSelect = k[0];
            sw = 15'($random(seed));
            addrSwitch = sw;
            idx = 8'($random(seed));
            if (idx[7:1] == 7'h10) idx = idx ^ 8'h40;
            v = 16'($random(seed));
            acc(mk(sw, k[0], idx, 8'($random(seed))), amTab[{k[0], k[1]}], 1'b1, v, 1'b1, 1'b0);
            acc(mk(sw, k[0], idx, 8'($random(seed))), amTab[{k[0], k[2]}], 1'b0, v, 1'b1, 1'b0);
            acc(mk(sw ^ (15'h1 << (k[0] ? 7 + k[3:1] : k[2:0])), k[0], idx, 8'h00), amTab[{k[0], 1'b0}],
                1'b0, v, 1'b0, 1'b0);
            acc(mk(sw, k[0], idx, 8'h00), amTab[{~k[0], 1'b1}], 1'b0, v, 1'b0, 1'b0);
            acc(mk(sw, k[0], idx, 8'h00), amTab[{k[0], 1'b0}], 1'b1, ~v, 1'b1, 1'b1);
            acc(mk(sw, k[0], idx, 8'h00), amTab[{k[0], 1'b1}], 1'b0, v, 1'b1, 1'b0);
            cpuEn = 1'b1;
            cpuAddr = idx;
            @(negedge core_clk) cpuWe = 1'b1;
            chkWord("cpuRdata", mem[idx], cpuRdata);
            cpuWdata = ~v;
            @(negedge core_clk) cpuEn = 1'b0;
            cpuWe = 1'b0;
            mem[idx] = ~v;
            acc(mk(sw, k[0], idx, 8'h00), amTab[{k[0], 1'b0}], 1'b0, v, 1'b1, 1'b0);
        end
        $display("test decode done");
        wideSpaceSelect = 1'b0;
        for (k = 0; k < 4; k++) begin
            v = 16'($random(seed));
            acc(mk(sw, 1'b0, RELAY_IDX, 8'h00), 6'h29, 1'b1, v, 1'b1, 1'b0);
            acc(mk(sw, 1'b0, RELAY_IDX, 8'h00), 6'h29, 1'b1, ~v, 1'b1, 1'b1);
            acc(mk(sw, 1'b0, MODE_IDX, 8'h00), 6'h2d, 1'b1, 16'(k), 1'b1, 1'b0);
            @(negedge core_clk);
            chkWord("relayOn", v, relayOn);
            chkBit("calBusEn", k[MODE_CALBUS_BIT], calBusEn);
            chkBit("checkResEn", k[MODE_CHECKRES_BIT], checkResEn);
        end
        $display("test relays done");
        for (k = 0; k < 8; k++) begin
            chain = 5'($random(seed));
            {iackInN, bgInN} = chain;
            @(negedge core_clk);
            chkWord("chains", {11'h0, chain}, {11'h0, iackOutN, bgOutN});
        end
        $display("test chains done");
        srst = 1'b1;
        @(negedge core_clk) srst = 1'b0;
        resetChk();
        $display("test second reset done");
        printVerdict();
    end
    initial begin
        #2000000;
        nMismatch++;
        printVerdict();
    end
endmodule : vme_slave_address_decode_bench
`default_nettype wire
